// ---- dv/rss_radio_regs_sva.sv ----
// Checker for the radio register bank, bound to its top module.
// Assumes masks change only while no flag is set.
`timescale 1ns/100ps
module rss_radio_regs_sva (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       SYS_RST,
   // Events
   input wire logic       RX_PAYLOAD_IN,
   input wire logic       TX_DONE,
   input wire logic       ACK_RECEIVED,
   input wire logic       AUTO_ACK_ON,
   input wire logic       RETRY_LIMIT,
   // Outputs watched
   input wire logic [1:0] DATA_RATE,
   input wire logic [1:0] TX_POWER_LEVEL,
   input wire logic       RX_GAIN_SELECT,
   input wire logic       FORCE_SYNTH_LOCK,
   input wire logic [7:0] CONFIG_BITS,
   input wire logic       BANK_INDICATOR,
   input wire logic       COMM_HALT,
   input wire logic       IRQ_N
);
   // ********
   // Properties
   // ********
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   // Reset values show on the first edge after release
   AST_RATE_RST: assert property ($fell(SYS_RST) |-> DATA_RATE == 2'h1 && TX_POWER_LEVEL == 2'h3)
      else $error("setup reset wrong");
   AST_GAIN_RST: assert property ($fell(SYS_RST) |-> RX_GAIN_SELECT && !FORCE_SYNTH_LOCK)
      else $error("gain or lock reset wrong");
   AST_RATE_CODE: assert property (DATA_RATE != 2'h3)
      else $error("rate code unused");
   AST_BANK_RST: assert property ($fell(SYS_RST) |-> !BANK_INDICATOR && !COMM_HALT && IRQ_N)
      else $error("bank or irq reset wrong");
   // Flag and pin move on the same edge
   AST_IRQ_RX: assert property (RX_PAYLOAD_IN && !CONFIG_BITS[6] |=> !IRQ_N)
      else $error("rx event no irq");
   AST_IRQ_TX: assert property (TX_DONE && !AUTO_ACK_ON && !CONFIG_BITS[5] |=> !IRQ_N)
      else $error("tx event no irq");
   AST_ACK_ONLY: assert property (TX_DONE && AUTO_ACK_ON && IRQ_N && !RX_PAYLOAD_IN && !ACK_RECEIVED
      && !RETRY_LIMIT |=> IRQ_N)
      else $error("tx flag set before ack");
   AST_HALT: assert property (RETRY_LIMIT |=> COMM_HALT)
      else $error("retry limit no halt");
   AST_HALT_IRQ: assert property (COMM_HALT && !CONFIG_BITS[4] |-> !IRQ_N)
      else $error("halt without irq");
endmodule
bind rss_radio_regs rss_radio_regs_sva rss_radio_regs_sva_inst (
   .CLK(CLK), .SYS_RST(SYS_RST), .RX_PAYLOAD_IN(RX_PAYLOAD_IN), .TX_DONE(TX_DONE),
   .ACK_RECEIVED(ACK_RECEIVED), .AUTO_ACK_ON(AUTO_ACK_ON), .RETRY_LIMIT(RETRY_LIMIT),
   .DATA_RATE(DATA_RATE), .TX_POWER_LEVEL(TX_POWER_LEVEL), .RX_GAIN_SELECT(RX_GAIN_SELECT),
   .FORCE_SYNTH_LOCK(FORCE_SYNTH_LOCK), .CONFIG_BITS(CONFIG_BITS), .BANK_INDICATOR(BANK_INDICATOR),
   .COMM_HALT(COMM_HALT), .IRQ_N(IRQ_N));

// ---- dv/rss_spi_host.sv ----
// Serial host model: mode 0, MSB first, 80 ns SCK only inside frames.
// Assumes one task call at a time from the bench.
`timescale 1ns/100ps
module rss_spi_host (
   // Link pins
   output logic      sck,
   output logic      csn,
   output logic      mosi,
   input  wire logic miso
);
   // ********
   // Frame tasks
   // ********
   initial begin
      sck = 1'h0;
      csn = 1'h1;
      mosi = 1'h0;
   end
   // One byte each way; MISO taken on the rise, it moves on the fall
   task automatic xb(input logic [7:0] t, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         mosi = t[i];
         #40 sck = 1'h1;
         q[i] = miso;
         #40 sck = 1'h0;
      end
   endtask
   // Select lead covers the output enable lag of about 3 CLK
   task automatic frame(input logic [7:0] c, input int n, input logic [39:0] d, output logic [47:0] q);
      #13 csn = 1'h0;
      #200 xb(c, q[7:0]);
      for (int k = 0; k < n; k++) xb(d[8*k +: 8], q[8+8*k +: 8]);
      #40 csn = 1'h1;
      #200;
   endtask
endmodule

// ---- dv/tb_radio_setup_status_registers.sv ----
// Self-checking bench for the radio register bank and a serial host model.
// Assumes each frame ends long after its register effects have landed.
`timescale 1ns/100ps
module tb_radio_setup_status_registers;
   // ********
   // Bench
   // ********
   logic        CLK = 1'h0, SYS_RST = 1'h1, aa = 1'h0, cs = 1'h0, emp = 1'h1, full = 1'h0;
   logic [6:0]  ev = 7'h00;
   logic [2:0]  hp = 3'h0;
   logic [31:0] rnd = 32'h5ca1;
   logic [47:0] r;
   logic [39:0] d;
   logic [7:0]  d8;
   wire         sck, csn, mosi, miso, miso_d, oe, gain, lock, bank, feat, halt, irq_n;
   wire  [1:0]  rate, pwr;
   wire  [6:0]  chan;
   wire  [39:0] p0, p1;
   int          n_errors = 0, compares = 0, rx = 0, tx = 0, rt = 0, bk = 0, lost = 0, rtc = 0, e, n;
   // Released line shows the inverse, never a stale bit
   assign miso = oe ? miso_d : ~miso_d;
   rss_radio_regs rss_radio_regs_inst (
      .CLK(CLK), .SYS_RST(SYS_RST), .SCK(sck), .CSN(csn), .MOSI(mosi), .MISO(miso_d), .MISO_OE(oe),
      .RX_PAYLOAD_IN(ev[0]), .TX_DONE(ev[1]), .ACK_RECEIVED(ev[2]), .AUTO_ACK_ON(aa),
      .RETRY_LIMIT(ev[3]), .TX_START(ev[4]), .TX_RETRY(ev[5]), .PACKET_LOST(ev[6]),
      .CARRIER_SENSE(cs), .RX_FIFO_EMPTY(emp), .RX_HEAD_PIPE(hp), .TX_FIFO_FULL(full),
      .DATA_RATE(rate), .TX_POWER_LEVEL(pwr), .RX_GAIN_SELECT(gain), .FORCE_SYNTH_LOCK(lock),
      .RADIO_CHANNEL(chan), .ADDRESS_WIDTH_SETTING(), .PIPE0_RECEIVE_ADDRESS(p0),
      .PIPE1_RECEIVE_ADDRESS(p1), .CONFIG_BITS(), .BANK_INDICATOR(bank), .FEATURES_ON(feat),
      .COMM_HALT(halt), .IRQ_N(irq_n));
   rss_spi_host rss_spi_host_inst (.sck(sck), .csn(csn), .mosi(mosi), .miso(miso));
   // Model status byte
   function automatic logic [7:0] st();
      return {bk[0], rx[0], tx[0], rt[0], emp ? 3'h7 : hp, full};
   endfunction
   function automatic logic [31:0] lf(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [47:0] s, input logic [47:0] x);
      compares++;
      if (s !== x) begin
         n_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // Negedge wait lets the pulse's effect land before any look
   task automatic pulse(input int b);
      @(posedge CLK) ev <= 7'h01 << b;
      @(posedge CLK) ev <= 7'h00;
      @(negedge CLK);
   endtask
   task automatic fr(input logic [7:0] c, input int k, input logic [39:0] v);
      @(posedge CLK);
      rss_spi_host_inst.frame(c, k, v, r);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial forever #20 CLK = ~CLK;
   // Hang guard
   initial begin
      #400000;
      n_errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'h0;
      repeat (4) @(posedge CLK);
      fr(8'h06, 1, 40'h0);
      chk(r[15:0], 16'h0F0E);
      $display("reset values done");
      for (int k = 0; k < 4; k++) begin
         rnd = lf(rnd);
         d8 = {2'h0, k[1], rnd[0], k[0], rnd[3:1]};
         e = (k == 3) ? 1 : k;
         fr(8'h26, 1, {32'h0, d8});
         fr(8'h06, 1, 40'h0);
         chk({r[15:8], rate, pwr, gain, lock}, {d8, e[1:0], d8[2:0], d8[4]});
      end
      $display("setup done");
      @(posedge CLK) aa <= 1'h1;
      pulse(1);
      chk(irq_n, 1'h1);
      pulse(2);
      tx = 1;
      pulse(0);
      rx = 1;
      pulse(3);
      rt = 1;
      @(posedge CLK);
      emp <= 1'h0;
      hp <= 3'(rnd % 6);
      full <= 1'h1;
      fr(8'h07, 1, 40'h0);
      chk({r[15:8], irq_n, halt}, {st(), 2'h1});
      fr(8'h27, 1, 40'h0);
      fr(8'h07, 1, 40'h0);
      chk({r[15:8], irq_n}, {st(), 1'h0});
      fr(8'h27, 1, 40'h70);
      rx = 0;
      tx = 0;
      rt = 0;
      chk({irq_n, halt}, 2'h2);
      @(posedge CLK) aa <= 1'h0;
      pulse(1);
      chk(irq_n, 1'h0);
      fr(8'h27, 1, 40'h20);
      chk(irq_n, 1'h1);
      $display("status flags done");
      n = rnd[4:0];
      for (int i = 0; i < n + 17; i++) begin
         pulse(i < n ? 5 : 6);
         if (i < n) rtc = (rtc < 15) ? rtc + 1 : 15;
         else lost = (lost < 15) ? lost + 1 : 15;
      end
      fr(8'h08, 1, 40'h0);
      chk(r[15:8], {lost[3:0], rtc[3:0]});
      fr(8'h25, 1, {32'h0, 1'h0, rnd[12:6]});
      lost = 0;
      fr(8'h08, 1, 40'h0);
      chk({r[15:8], chan}, {lost[3:0], rtc[3:0], rnd[12:6]});
      pulse(4);
      rtc = 0;
      fr(8'h08, 1, 40'h0);
      chk(r[15:8], {lost[3:0], rtc[3:0]});
      $display("counters done");
      rnd = lf(rnd);
      d = {rnd[7:0], rnd};
      fr(8'h2B, 5, d);
      chk(p1, d);
      fr(8'h23, 1, 40'h1);
      fr(8'h2A, 3, d);
      chk(p0, {16'hE7E7, d[23:0]});
      $display("pipe address done");
      fr(8'h50, 1, 40'h53);
      bk = 1;
      fr(8'h07, 1, 40'h0);
      chk({r[15:8], bank, feat}, {st(), 2'h2});
      fr(8'h50, 1, 40'h53);
      fr(8'h50, 1, 40'h73);
      bk = 0;
      chk({bank, feat}, 2'h1);
      @(posedge CLK) cs <= 1'h1;
      fr(8'h09, 1, 40'h0);
      chk(r[15:8], 8'h01);
      fr(8'h20, 1, 40'h78);
      pulse(0);
      chk(irq_n, 1'h1);
      $display("bank and carrier done");
      end_of_test();
   end
endmodule

// ---- hw/rss_pkg.sv ----
// Constants shared by the radio register bank and its serial link.
// Assumes bank 0 register addresses; bank 1 contents are not held here.
package rss_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [4:0] ADDR_CONFIG      = 5'h00;
   localparam logic [4:0] ADDR_ADDR_WIDTH  = 5'h03;
   localparam logic [4:0] ADDR_CHANNEL     = 5'h05;
   localparam logic [4:0] ADDR_RADIO_SETUP = 5'h06;
   localparam logic [4:0] ADDR_STATUS      = 5'h07;
   localparam logic [4:0] ADDR_TX_OBSERVE  = 5'h08;
   localparam logic [4:0] ADDR_CARRIER     = 5'h09;
   localparam logic [4:0] ADDR_PIPE0       = 5'h0A;
   localparam logic [4:0] ADDR_PIPE1       = 5'h0B;

   // ****************************************
   // Command bytes
   // ****************************************
   localparam logic [2:0] OP_READ_PREFIX  = 3'h0;
   localparam logic [2:0] OP_WRITE_PREFIX = 3'h1;
   localparam logic [7:0] OP_ACTIVATE     = 8'h50;
   localparam logic [7:0] OP_NOP          = 8'hFF;
   localparam logic [7:0] ARG_BANK_TOGGLE = 8'h53;
   localparam logic [7:0] ARG_FEAT_TOGGLE = 8'h73;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int SETUP_RATE_LOW  = 5;
   localparam int SETUP_LOCK      = 4;
   localparam int SETUP_RATE_HIGH = 3;
   localparam int SETUP_PWR_LSB   = 1;
   localparam int SETUP_GAIN      = 0;
   localparam int CFG_MASK_RX     = 6;
   localparam int CFG_MASK_TX     = 5;
   localparam int CFG_MASK_RT     = 4;
   localparam int ST_RX_FLAG      = 6;
   localparam int ST_TX_FLAG      = 5;
   localparam int ST_RT_FLAG      = 4;

   // ****************************************
   // Reset values and limits
   // ****************************************
   localparam logic [7:0]  CONFIG_RST  = 8'h08;
   localparam logic [1:0]  AW_RST      = 2'h3;
   localparam logic [6:0]  CHANNEL_RST = 7'h02;
   localparam logic [5:0]  SETUP_RST   = 6'h0F;
   localparam logic [39:0] PIPE0_RST   = 40'hE7_E7E7_E7E7;
   localparam logic [39:0] PIPE1_RST   = 40'hC2_C2C2_C2C2;
   localparam logic [2:0]  PIPE_EMPTY  = 3'h7;
   localparam logic [7:0]  STATUS_RST  = 8'h0E;
   localparam logic [3:0]  COUNT_MAX   = 4'hF;
   localparam logic [2:0]  AW_BIAS     = 3'h2;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      RATE_1M   = 2'h0,
      RATE_2M   = 2'h1,
      RATE_250K = 2'h2
   } rss_rate_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CMD  = 3'b010,
      ST_DATA = 3'b100
   } rss_state_type;

endpackage

// ---- hw/rss_radio_regs.sv ----
// Radio setup, status and observation registers with their serial host port.
// Assumes the radio engine runs on CLK and gives one-cycle event pulses; SCK belongs to the host.
//
// Function
// R01 - Data rate from low/high bits: 00 1M, 01 or 11 2M, 10 250K.
// R02 - Test bit forcing synthesizer lock, reset zero.
// R03 - Transmit power from setup bits 2:1, reset 11.
// R04 - Setup bit 0 picks receive gain, one high, reset one.
// R05 - Status byte shifts out while the command byte shifts in.
// R06 - Status bit 7 shows bank; activate plus 0x53 toggles it.
// R07 - Status bit 6 sets when a payload reaches the receive queue.
// R08 - Status bit 5 sets on sent packet, or on ack when enabled.
// R09 - Status bit 4 sets when retransmissions run out.
// R10 - Writing one clears a flag; writing zero leaves it.
// R11 - Retry-limit flag halts communication until host clears it.
// R12 - Status bits 3:1 show head pipe, 111 when receive queue empty.
// R13 - Lost packet count in observe bits 7:4, saturating at 15.
// R14 - Writing the channel register clears the lost packet count.
// R15 - Retry count in observe bits 3:0, cleared when a packet starts.
// R16 - Pipe addresses assembled low byte first, width bytes long.
// R17 - Interrupt pin low while any unmasked flag is set.
// R18 - Interrupt pin released once the causing flags are cleared.
// R19 - Opcode 0x50 plus one data byte selects bank or feature action.
// R20 - Host writes zero to setup bits 7:6.
// R21 - Carrier detect register bit 0 follows sensed carrier, reset zero.
`timescale 1ns/100ps
module rss_radio_regs (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // Serial host port
   input  wire logic        SCK,
   input  wire logic        CSN,
   input  wire logic        MOSI,
   output logic             MISO,
   output logic             MISO_OE,
   // Radio engine events
   input  wire logic        RX_PAYLOAD_IN,
   input  wire logic        TX_DONE,
   input  wire logic        ACK_RECEIVED,
   input  wire logic        AUTO_ACK_ON,
   input  wire logic        RETRY_LIMIT,
   input  wire logic        TX_START,
   input  wire logic        TX_RETRY,
   input  wire logic        PACKET_LOST,
   input  wire logic        CARRIER_SENSE,
   input  wire logic        RX_FIFO_EMPTY,
   input  wire logic [2:0]  RX_HEAD_PIPE,
   input  wire logic        TX_FIFO_FULL,
   // Radio setup outputs
   output logic [1:0]       DATA_RATE,
   output logic [1:0]       TX_POWER_LEVEL,
   output logic             RX_GAIN_SELECT,
   output logic             FORCE_SYNTH_LOCK,
   output logic [6:0]       RADIO_CHANNEL,
   output logic [1:0]       ADDRESS_WIDTH_SETTING,
   output logic [39:0]      PIPE0_RECEIVE_ADDRESS,
   output logic [39:0]      PIPE1_RECEIVE_ADDRESS,
   output logic [7:0]       CONFIG_BITS,
   output logic             BANK_INDICATOR,
   output logic             FEATURES_ON,
   // Halt and interrupt
   output logic             COMM_HALT,
   output logic             IRQ_N
);

   // ********
   // Declarations
   // ********
   logic                  link_rst_r;
   logic                  csn_s1_r;
   logic                  csn_s2_r;
   logic                  tgl_s1_r;
   logic                  tgl_s2_r;
   logic                  tgl_seen_r;
   logic                  miso_oe_r;
   rss_pkg::rss_state_type state_r;
   rss_pkg::rss_state_type state_nxt;
   logic [7:0]            cmd_r;
   logic [7:0]            config_r;
   logic [1:0]            aw_r;
   logic [6:0]            channel_r;
   logic [5:0]            setup_r;
   logic [39:0]           pipe_addr_r [2];
   logic                  bank_r;
   logic                  feature_r;
   logic                  rx_flag_r;
   logic                  tx_flag_r;
   logic                  rt_flag_r;
   logic [2:0]            pipe_no_r;
   logic                  tx_full_r;
   logic [3:0]            lost_r;
   logic [3:0]            retry_r;
   logic                  cd_r;
   logic                  irq_n_r;
   rss_pkg::rss_rate_type rate_r;
   logic                  rx_flag_nxt;
   logic                  tx_flag_nxt;
   logic                  rt_flag_nxt;
   logic                  link_miso;
   logic [7:0]            live_cmd;
   logic [2:0]            live_idx;
   logic                  link_tgl;
   logic [7:0]            hold_byte;
   logic [2:0]            hold_idx;
   logic [7:0]            reg_byte;
   logic [7:0]            tx_byte;

   // ********
   // Decoding helpers
   // ********
   // Bytes a register spans: pipe addresses follow the width setting
   function automatic logic [2:0] reg_len(input logic [4:0] addr, input logic [1:0] aw);
      logic pipe;
      pipe = (addr == rss_pkg::ADDR_PIPE0) || (addr == rss_pkg::ADDR_PIPE1);
      reg_len = pipe ? ({1'b0, aw} + rss_pkg::AW_BIAS) : 3'h1;
   endfunction

   // Rate decode; 11 falls back to the high rate as 01 does
   function automatic rss_pkg::rss_rate_type rate_of(input logic low, input logic high);
      rate_of = low ? (high ? rss_pkg::RATE_2M : rss_pkg::RATE_250K)
                    : (high ? rss_pkg::RATE_2M : rss_pkg::RATE_1M);
   endfunction

   // ********
   // Serial link and crossings
   // ********
   rss_spi_link rss_spi_link_inst (
      .sck       (SCK),
      .csn       (CSN),
      .mosi      (MOSI),
      .miso      (link_miso),
      .link_rst  (link_rst_r),
      .tx_byte   (tx_byte),
      .live_cmd  (live_cmd),
      .live_idx  (live_idx),
      .done_tgl  (link_tgl),
      .hold_byte (hold_byte),
      .hold_idx  (hold_idx)
   );

   // Select and byte toggle through two flops; hold_byte is steady once the toggle lands
   always_ff @(posedge CLK) begin
      link_rst_r <= SYS_RST;
      csn_s1_r   <= CSN;
      csn_s2_r   <= csn_s1_r;
      tgl_s1_r   <= link_tgl;
      tgl_s2_r   <= tgl_s1_r;
      if (SYS_RST) begin
         tgl_seen_r <= tgl_s2_r;
         miso_oe_r  <= 1'b0;
      end else begin
         tgl_seen_r <= tgl_s2_r;
         miso_oe_r  <= ~csn_s2_r;
      end
   end

   // ********
   // Command decode
   // ********
   wire       byte_stb  = tgl_s2_r ^ tgl_seen_r;
   wire       cmd_stb   = byte_stb && (hold_idx == 3'h0);
   wire       data_stb  = byte_stb && (hold_idx != 3'h0) && (state_r == rss_pkg::ST_DATA);
   wire [4:0] wr_addr   = cmd_r[4:0];
   wire [2:0] data_pos  = hold_idx - 3'h1;
   wire       wr_reg    = data_stb && (cmd_r[7:5] == rss_pkg::OP_WRITE_PREFIX) && !bank_r;
   wire       wr_ok     = wr_reg && (hold_idx <= reg_len(wr_addr, aw_r));
   wire       wr_cfg    = wr_ok && (wr_addr == rss_pkg::ADDR_CONFIG);
   wire       wr_aw     = wr_ok && (wr_addr == rss_pkg::ADDR_ADDR_WIDTH);
   wire       wr_chan   = wr_ok && (wr_addr == rss_pkg::ADDR_CHANNEL);
   wire       wr_setup  = wr_ok && (wr_addr == rss_pkg::ADDR_RADIO_SETUP);
   wire       wr_status = wr_ok && (wr_addr == rss_pkg::ADDR_STATUS);
   wire       activate  = data_stb && (cmd_r == rss_pkg::OP_ACTIVATE) && (hold_idx == 3'h1);   // R19
   wire       bank_flip = activate && (hold_byte == rss_pkg::ARG_BANK_TOGGLE);
   wire       feat_flip = activate && (hold_byte == rss_pkg::ARG_FEAT_TOGGLE);

   // Frame tracking; a byte landing with the deselect is still taken
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rss_pkg::ST_IDLE: state_nxt = csn_s2_r ? rss_pkg::ST_IDLE : rss_pkg::ST_CMD;
         rss_pkg::ST_CMD:  state_nxt = cmd_stb ? rss_pkg::ST_DATA
                                       : (csn_s2_r ? rss_pkg::ST_IDLE : rss_pkg::ST_CMD);
         rss_pkg::ST_DATA: state_nxt = (csn_s2_r && !byte_stb) ? rss_pkg::ST_IDLE : rss_pkg::ST_DATA;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_r <= rss_pkg::ST_IDLE;
         cmd_r   <= rss_pkg::OP_NOP;
      end else begin
         state_r <= state_nxt;
         if (cmd_stb) begin
            cmd_r <= hold_byte;
         end
      end
   end

   // ********
   // Setup registers
   // ********
   // Setup bits 7:6 are not stored and read back as zero
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         config_r  <= rss_pkg::CONFIG_RST;
         aw_r      <= rss_pkg::AW_RST;
         channel_r <= rss_pkg::CHANNEL_RST;
         setup_r   <= rss_pkg::SETUP_RST;                // R02 R03 R04
         bank_r    <= 1'b0;
         feature_r <= 1'b0;
         rate_r    <= rss_pkg::RATE_2M;
      end else begin
         if (wr_cfg)    config_r  <= hold_byte;
         if (wr_aw)     aw_r      <= hold_byte[1:0];
         if (wr_chan)   channel_r <= hold_byte[6:0];
         if (wr_setup)  setup_r   <= hold_byte[5:0];     // R20
         if (bank_flip) bank_r    <= ~bank_r;            // R06
         if (feat_flip) feature_r <= ~feature_r;
         rate_r <= rate_of(setup_r[rss_pkg::SETUP_RATE_LOW], setup_r[rss_pkg::SETUP_RATE_HIGH]);   // R01
      end
   end

   // Pipe addresses, one byte per data byte, low byte first
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_pipe
         wire [4:0] pipe_code = (p == 0) ? rss_pkg::ADDR_PIPE0 : rss_pkg::ADDR_PIPE1;
         wire       wr_pipe   = wr_ok && (wr_addr == pipe_code);
         always_ff @(posedge CLK) begin
            if (SYS_RST) begin
               pipe_addr_r[p] <= (p == 0) ? rss_pkg::PIPE0_RST : rss_pkg::PIPE1_RST;
            end else if (wr_pipe) begin
               pipe_addr_r[p][8 * data_pos +: 8] <= hold_byte;   // R16
            end
         end
      end
   endgenerate

   // ********
   // Status flags and counters
   // ********
   // Set beats clear, so an event in the clearing cycle survives
   wire tx_event = AUTO_ACK_ON ? ACK_RECEIVED : TX_DONE;   // R08
   assign rx_flag_nxt = RX_PAYLOAD_IN                                            // R07
                      | (rx_flag_r & ~(wr_status & hold_byte[rss_pkg::ST_RX_FLAG]));   // R10
   assign tx_flag_nxt = tx_event
                      | (tx_flag_r & ~(wr_status & hold_byte[rss_pkg::ST_TX_FLAG]));   // R10
   assign rt_flag_nxt = RETRY_LIMIT                                              // R09
                      | (rt_flag_r & ~(wr_status & hold_byte[rss_pkg::ST_RT_FLAG]));   // R10

   wire irq_any = (rx_flag_nxt & ~config_r[rss_pkg::CFG_MASK_RX])
                | (tx_flag_nxt & ~config_r[rss_pkg::CFG_MASK_TX])
                | (rt_flag_nxt & ~config_r[rss_pkg::CFG_MASK_RT]);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rx_flag_r <= 1'b0;
         tx_flag_r <= 1'b0;
         rt_flag_r <= 1'b0;
         irq_n_r   <= 1'b1;
      end else begin
         rx_flag_r <= rx_flag_nxt;
         tx_flag_r <= tx_flag_nxt;
         rt_flag_r <= rt_flag_nxt;                       // R11
         irq_n_r   <= ~irq_any;                          // R17 R18
      end
   end

   // Observed state; a channel write wins over a loss in the same cycle, counting it
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pipe_no_r <= rss_pkg::PIPE_EMPTY;
         tx_full_r <= 1'b0;
         lost_r    <= 4'h0;
         retry_r   <= 4'h0;
         cd_r      <= 1'b0;
      end else begin
         pipe_no_r <= RX_FIFO_EMPTY ? rss_pkg::PIPE_EMPTY : RX_HEAD_PIPE;   // R12
         tx_full_r <= TX_FIFO_FULL;
         cd_r      <= CARRIER_SENSE;                     // R21
         if (wr_chan) begin
            lost_r <= {3'h0, PACKET_LOST};               // R14
         end else if (PACKET_LOST && lost_r != rss_pkg::COUNT_MAX) begin
            lost_r <= lost_r + 4'h1;                     // R13
         end
         if (TX_START) begin
            retry_r <= 4'h0;                             // R15
         end else if (TX_RETRY && retry_r != rss_pkg::COUNT_MAX) begin
            retry_r <= retry_r + 4'h1;
         end
      end
   end

   // ********
   // Read path toward the link
   // ********
   // Sampled by the link at byte ends only; sources change rarely, so a torn sample is
   // limited to a flag that flips in that edge
   wire [7:0] status_byte = {bank_r, rx_flag_r, tx_flag_r, rt_flag_r, pipe_no_r, tx_full_r};   // R06 R12
   wire [4:0] rd_addr     = live_cmd[4:0];
   wire [2:0] rd_pos      = live_idx - 3'h1;
   wire       rd_hit      = (live_cmd[7:5] == rss_pkg::OP_READ_PREFIX) && !bank_r
                          && (live_idx != 3'h0) && (live_idx <= reg_len(rd_addr, aw_r));

   always_comb begin
      unique case (rd_addr)
         rss_pkg::ADDR_CONFIG:      reg_byte = config_r;
         rss_pkg::ADDR_ADDR_WIDTH:  reg_byte = {6'h00, aw_r};
         rss_pkg::ADDR_CHANNEL:     reg_byte = {1'b0, channel_r};
         rss_pkg::ADDR_RADIO_SETUP: reg_byte = {2'h0, setup_r};
         rss_pkg::ADDR_STATUS:      reg_byte = status_byte;
         rss_pkg::ADDR_TX_OBSERVE:  reg_byte = {lost_r, retry_r};
         rss_pkg::ADDR_CARRIER:     reg_byte = {7'h00, cd_r};
         rss_pkg::ADDR_PIPE0:       reg_byte = pipe_addr_r[0][8 * rd_pos +: 8];
         rss_pkg::ADDR_PIPE1:       reg_byte = pipe_addr_r[1][8 * rd_pos +: 8];
         default:                   reg_byte = 8'h00;
      endcase
   end

   // Status fills every byte that is not read data, the command byte above all
   assign tx_byte = rd_hit ? reg_byte : status_byte;    // R05

   // ********
   // Outputs
   // ********
   assign MISO                  = link_miso;
   assign MISO_OE               = miso_oe_r;
   assign DATA_RATE             = rate_r;
   assign TX_POWER_LEVEL        = setup_r[rss_pkg::SETUP_PWR_LSB +: 2];   // R03
   assign RX_GAIN_SELECT        = setup_r[rss_pkg::SETUP_GAIN];           // R04
   assign FORCE_SYNTH_LOCK      = setup_r[rss_pkg::SETUP_LOCK];           // R02
   assign RADIO_CHANNEL         = channel_r;
   assign ADDRESS_WIDTH_SETTING = aw_r;
   assign PIPE0_RECEIVE_ADDRESS = pipe_addr_r[0];
   assign PIPE1_RECEIVE_ADDRESS = pipe_addr_r[1];
   assign CONFIG_BITS           = config_r;
   assign BANK_INDICATOR        = bank_r;
   assign FEATURES_ON           = feature_r;
   assign COMM_HALT             = rt_flag_r;            // R11
   assign IRQ_N                 = irq_n_r;

endmodule

// ---- hw/rss_spi_link.sv ----
// Serial link shifter on the host's SCK, mode 0, MSB first.
// Assumes SCK idles low and the core holds tx_byte steady around byte ends.
`timescale 1ns/100ps
module rss_spi_link (
   // Link pins
   input  wire logic       sck,
   input  wire logic       csn,
   input  wire logic       mosi,
   output logic            miso,
   // Core side
   input  wire logic       link_rst,
   input  wire logic [7:0] tx_byte,
   output logic [7:0]      live_cmd,
   output logic [2:0]      live_idx,
   output logic            done_tgl,
   output logic [7:0]      hold_byte,
   output logic [2:0]      hold_idx
);

   logic [2:0] bit_cnt_r;
   logic [2:0] byte_idx_r;
   logic [6:0] shift_in_r;
   logic [7:0] shift_out_r;
   logic       tgl_r;
   logic [7:0] hold_byte_r;
   logic [2:0] hold_idx_r;
   logic [7:0] cmd_r;

   // ********
   // Receive side
   // ********
   wire [7:0] in_byte  = {shift_in_r, mosi};
   wire       byte_end = (bit_cnt_r == 3'h7);

   // Frame counters, cleared while deselected
   always_ff @(posedge sck or posedge csn) begin
      if (csn) begin
         bit_cnt_r  <= 3'h0;
         byte_idx_r <= 3'h0;
         shift_in_r <= 7'h00;
      end else begin
         bit_cnt_r  <= bit_cnt_r + 3'h1;
         shift_in_r <= in_byte[6:0];
         if (byte_end && byte_idx_r != 3'h7) begin
            byte_idx_r <= byte_idx_r + 3'h1;
         end
      end
   end

   // Finished byte held for a whole byte time, so the core can take it late
   always_ff @(posedge sck or posedge link_rst) begin
      if (link_rst) begin
         tgl_r       <= 1'b0;
         hold_byte_r <= 8'h00;
         hold_idx_r  <= 3'h0;
         cmd_r       <= rss_pkg::OP_NOP;
      end else if (byte_end) begin
         tgl_r       <= ~tgl_r;
         hold_byte_r <= in_byte;
         hold_idx_r  <= byte_idx_r;
         if (byte_idx_r == 3'h0) begin
            cmd_r <= in_byte;
         end
      end
   end

   // ********
   // Transmit side
   // ********
   // Next byte loaded on the falling edge that ends each byte; the last one of a frame
   // preloads the status for the next frame, since no edge comes at select time
   always_ff @(negedge sck or posedge link_rst) begin
      if (link_rst) begin
         shift_out_r <= rss_pkg::STATUS_RST;
      end else if (bit_cnt_r == 3'h0) begin
         shift_out_r <= tx_byte;                         // R05
      end else begin
         shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
   end

   assign miso      = shift_out_r[7];
   assign live_cmd  = cmd_r;
   assign live_idx  = byte_idx_r;
   assign done_tgl  = tgl_r;
   assign hold_byte = hold_byte_r;
   assign hold_idx  = hold_idx_r;

endmodule
